// [hw/frusc_cmd.v]
// Operation
// RL1 - no-op only cancels a pending reset arm
// RL2 - reset executes only after completed reset arm
// RL3 - any other command discards the arm
// RL4 - software reset restores power-on defaults, standby
// RL5 - reset during program or erase aborts it
// RL6 - fixed read-only 128-bit unique identifier
// RL7 - unique id: opcode, four dummy bytes, id out
// RL8 - table read: opcode, three address, one dummy
// RL9 - chip select high ends table output
// RL10 - signature bytes 53 46 44 50
// RL11 - revisions 00, 01, header count 01
// RL12 - first header and its table pointer
// RL13 - second vendor header and its pointer
// RL14 - unused header bytes read FF
// RL15 - opcodes 00, 66, 99 always accepted
// RL16 - table address increments after each byte
// RL17 - msb first, one bit per clock
`timescale 1ns/1ps
`include "frusc_consts.vh"
module frusc_cmd #(
   // arbitrary neutral values
   parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEFFEDCBA9876543210,
   parameter [7:0]   VENDOR_ID = 8'h5C
) (
   // clock and reset
   input  wire       clock_i,
   input  wire       rst_b_i,
   // serial link pins
   input  wire       cs_b_i,
   input  wire       sclk_i,
   input  wire       si_i,
   input  wire [2:0] upper_io_lines_i,
   output reg        so_o,
   output reg        so_oe_o,
   // array engine status and control
   input  wire       busy_i,
   output reg        abort_o,
   output reg        soft_reset_o
);
   localparam [5:0] ST_OPC  = 6'b000001;
   localparam [5:0] ST_ADDR = 6'b000010;
   localparam [5:0] ST_DUMY = 6'b000100;
   localparam [5:0] ST_UID  = 6'b001000;
   localparam [5:0] ST_TBL  = 6'b010000;
   localparam [5:0] ST_IDLE = 6'b100000;

   // ==========================================================
   // pin synchronisers
   wire cs_b_s;
   wire sclk_s;
   wire si_s;
   frusc_sync #(
      .RST_VAL (1'b1)
   ) u_sync_cs (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .d_i     (cs_b_i),
      .q_o     (cs_b_s)
   );

   frusc_sync #(
      .RST_VAL (1'b0)
   ) u_sync_ck (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .d_i     (sclk_i),
      .q_o     (sclk_s)
   );

   frusc_sync #(
      .RST_VAL (1'b0)
   ) u_sync_si (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .d_i     (si_i),
      .q_o     (si_s)
   );

   reg  sclk_d_reg;
   reg  cs_d_reg;
   wire rise    = sclk_s & ~sclk_d_reg & ~cs_b_s;
   wire fall    = ~sclk_s & sclk_d_reg & ~cs_b_s;
   wire cs_rise = cs_b_s & ~cs_d_reg;

   // ==========================================================
   // frame state
   reg [5:0]   state_reg;
   reg [7:0]   shift_reg;
   reg [2:0]   bit_reg;
   reg [1:0]   bytes_reg;
   reg         is_uid_reg;
   reg         arm_reg;
   reg [23:0]  addr_reg;
   reg [6:0]   uid_bit_reg;
   reg         first_byte_reg;
   reg [7:0]   out_sh_reg;
   reg [2:0]   out_cnt_reg;
   reg         out_have_reg;
   wire [7:0]  rx_byte   = {shift_reg[6:0], si_s};
   wire        byte_done = rise & (bit_reg == 3'd7);

   // ==========================================================
   // opcode decode, the upper io lines never reach it
   wire        op_arm    = (rx_byte == `FRUSC_OP_RESET_ARM);   // see RL15
   wire        op_exec   = (rx_byte == `FRUSC_OP_RESET_EXEC);
   wire        op_uid    = (rx_byte == `FRUSC_OP_UID_READ);
   wire        op_tbl    = (rx_byte == `FRUSC_OP_TABLE_READ);
   wire        exec_now  = byte_done & (state_reg == ST_OPC) & op_exec & arm_reg; // see RL2

   // ==========================================================
   // parameter table header lookup
   reg [7:0] tbl_byte;
   always @* begin
      if (addr_reg[23:5] != 19'd0) begin
         tbl_byte = `FRUSC_UNUSED_BYTE;
      end else begin
         case (addr_reg[4:0])
            5'h00: tbl_byte = `FRUSC_SIG_B0;     // see RL10
            5'h01: tbl_byte = `FRUSC_SIG_B1;
            5'h02: tbl_byte = `FRUSC_SIG_B2;
            5'h03: tbl_byte = `FRUSC_SIG_B3;
            5'h04: tbl_byte = `FRUSC_REV_MINOR;  // see RL11
            5'h05: tbl_byte = `FRUSC_REV_MAJOR;
            5'h06: tbl_byte = `FRUSC_HDR_COUNT;
            5'h07: tbl_byte = `FRUSC_UNUSED_BYTE; // see RL14
            5'h08: tbl_byte = `FRUSC_HDR0_ID;    // see RL12
            5'h09: tbl_byte = `FRUSC_REV_MINOR;
            5'h0A: tbl_byte = `FRUSC_REV_MAJOR;
            5'h0B: tbl_byte = `FRUSC_HDR0_LEN;
            5'h0C: tbl_byte = `FRUSC_HDR0_PTR;
            5'h0D: tbl_byte = `FRUSC_ZERO_BYTE;
            5'h0E: tbl_byte = `FRUSC_ZERO_BYTE;
            5'h0F: tbl_byte = `FRUSC_UNUSED_BYTE;
            5'h10: tbl_byte = VENDOR_ID;         // see RL13
            5'h11: tbl_byte = `FRUSC_REV_MINOR;
            5'h12: tbl_byte = `FRUSC_REV_MAJOR;
            5'h13: tbl_byte = `FRUSC_HDR1_LEN;
            5'h14: tbl_byte = `FRUSC_HDR1_PTR;
            5'h15: tbl_byte = `FRUSC_ZERO_BYTE;
            5'h16: tbl_byte = `FRUSC_ZERO_BYTE;
            5'h17: tbl_byte = `FRUSC_UNUSED_BYTE;
            default: tbl_byte = `FRUSC_UNUSED_BYTE; // see RL14
         endcase
      end
   end

   // uid byte, msb first
   wire [7:0] uid_byte = UNIQUE_ID[{~uid_bit_reg[6:3], 3'b111} -: 8]; // see RL6

   // ==========================================================
   // output byte buffer
   wire       in_tbl    = (state_reg == ST_TBL);
   wire       in_uid    = (state_reg == ST_UID);
   // identifier bytes stop once the last one is queued
   wire       src_valid = in_tbl | (in_uid & ~first_byte_reg);
   wire [7:0] src_data  = in_uid ? uid_byte : tbl_byte;
   wire       src_ready;
   wire [7:0] buf_data;
   wire       buf_valid;
   wire       buf_take  = buf_valid & ~out_have_reg;
   wire       src_push  = src_valid & src_ready;

   frusc_buf2 u_buf (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .flush_i     (cs_b_s),
      .in_data_i   (src_data),
      .in_valid_i  (src_valid),
      .in_ready_o  (src_ready),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_take)
   );

   // ==========================================================
   // command decode
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_d_reg     <= 1'b0;
         cs_d_reg       <= 1'b1;
         state_reg      <= ST_OPC;
         shift_reg      <= 8'h00;
         bit_reg        <= 3'd0;
         bytes_reg      <= 2'd0;
         is_uid_reg     <= 1'b0;
         arm_reg        <= `FRUSC_ARM_RST;
         addr_reg       <= 24'h000000;
         uid_bit_reg    <= 7'd0;
         first_byte_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_d_reg   <= cs_b_s;
         if (cs_b_s) begin
            state_reg <= ST_OPC;  // see RL9
            bit_reg   <= 3'd0;
         end else if (rise) begin
            shift_reg <= rx_byte;
            bit_reg   <= bit_reg + 3'd1;
         end
         if (byte_done) begin
            case (state_reg)
               ST_OPC: begin
                  arm_reg   <= op_arm;  // see RL1 RL3
                  state_reg <= ST_IDLE;
                  bytes_reg <= 2'd0;
                  if (op_exec && arm_reg) begin
                     // address, identifier pointer and frame flags back to power-on values
                     addr_reg       <= 24'h000000;  // see RL4
                     uid_bit_reg    <= 7'd0;
                     is_uid_reg     <= 1'b0;
                     first_byte_reg <= 1'b1;
                  end
                  if (op_uid) begin
                     is_uid_reg <= 1'b1;      // see RL7
                     state_reg  <= ST_DUMY;
                  end
                  if (op_tbl) begin
                     is_uid_reg <= 1'b0;      // see RL8
                     state_reg  <= ST_ADDR;
                  end
               end
               ST_ADDR: begin
                  addr_reg  <= {addr_reg[15:0], rx_byte};
                  bytes_reg <= bytes_reg + 2'd1;
                  if (bytes_reg == 2'd2) begin
                     state_reg <= ST_DUMY;
                     bytes_reg <= 2'd0;
                  end
               end
               ST_DUMY: begin
                  bytes_reg <= bytes_reg + 2'd1;  // see RL7 RL8
                  if (is_uid_reg ? (bytes_reg == 2'd3) : 1'b1) begin
                     state_reg      <= is_uid_reg ? ST_UID : ST_TBL;
                     uid_bit_reg    <= 7'd0;
                     first_byte_reg <= 1'b0;
                  end
               end
               ST_UID, ST_TBL, ST_IDLE: begin
                  // trailing bytes of a decoded frame carry no command
                  state_reg <= state_reg;
               end
               default: state_reg <= ST_OPC;
            endcase
         end
         if (src_push && !cs_b_s) begin
            if (state_reg == ST_TBL) begin
               addr_reg <= addr_reg + 24'd1;  // see RL16
            end else begin
               uid_bit_reg <= uid_bit_reg + 7'd8;
               if (uid_bit_reg == 7'd120) begin
                  first_byte_reg <= 1'b1;
               end
            end
         end
         if (cs_rise) begin
            first_byte_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // software reset request pulses
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         soft_reset_o <= 1'b0;
         abort_o      <= 1'b0;
      end else begin
         soft_reset_o <= exec_now;           // see RL2 RL4
         abort_o      <= exec_now & busy_i;  // see RL5
      end
   end

   // ==========================================================
   // serial output shifter, msb first on falling edges
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_sh_reg   <= 8'h00;
         out_cnt_reg  <= 3'd0;
         out_have_reg <= 1'b0;
         so_o         <= 1'b0;
         so_oe_o      <= 1'b0;
      end else if (cs_b_s) begin
         out_have_reg <= 1'b0;
         out_cnt_reg  <= 3'd0;
         so_oe_o      <= 1'b0;  // see RL9
      end else begin
         if (buf_take) begin
            out_sh_reg   <= buf_data;
            out_have_reg <= 1'b1;
            out_cnt_reg  <= 3'd0;
         end else if (fall && out_have_reg) begin
            so_o        <= out_sh_reg[7];  // see RL17
            so_oe_o     <= 1'b1;
            out_sh_reg  <= {out_sh_reg[6:0], 1'b0};
            out_cnt_reg <= out_cnt_reg + 3'd1;
            if (out_cnt_reg == 3'd7) begin
               out_have_reg <= 1'b0;
            end
         end
      end
   end
endmodule // frusc_cmd

// [hw/frusc_consts.vh]
`ifndef FRUSC_CONSTS_VH
`define FRUSC_CONSTS_VH

// ==========================================================
// opcodes
`define FRUSC_OP_NO_OP        8'h00
`define FRUSC_OP_RESET_ARM    8'h66
`define FRUSC_OP_RESET_EXEC   8'h99
`define FRUSC_OP_UID_READ     8'h4B
`define FRUSC_OP_TABLE_READ   8'h5A

// ==========================================================
// frame layout after the opcode
`define FRUSC_UID_DUMMY_BYTES 4
`define FRUSC_UID_BITS        128
`define FRUSC_TBL_ADDR_BYTES  3
`define FRUSC_TBL_DUMMY_BYTES 1

// ==========================================================
// parameter table header bytes
`define FRUSC_SIG_B0          8'h53
`define FRUSC_SIG_B1          8'h46
`define FRUSC_SIG_B2          8'h44
`define FRUSC_SIG_B3          8'h50
`define FRUSC_REV_MINOR       8'h00
`define FRUSC_REV_MAJOR       8'h01
`define FRUSC_HDR_COUNT       8'h01
`define FRUSC_HDR0_ID         8'h00
`define FRUSC_HDR0_LEN        8'h09
`define FRUSC_HDR0_PTR        8'h30
`define FRUSC_HDR1_LEN        8'h03
`define FRUSC_HDR1_PTR        8'h60
`define FRUSC_UNUSED_BYTE     8'hFF
`define FRUSC_ZERO_BYTE       8'h00

// ==========================================================
// reset values
`define FRUSC_ARM_RST         1'b0

`endif

// [hw/frusc_sync.v]
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser
module frusc_sync #(
   // level held in reset, the idle level of the pin
   parameter [0:0] RST_VAL = 1'b0
) (
   // clock and reset
   input  wire clock_i,
   input  wire rst_b_i,
   // level in and out
   input  wire d_i,
   output wire q_o
);
   reg meta_reg;
   reg sync_reg;

   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule // frusc_sync

// [hw/frusc_buf2.v]
`timescale 1ns/1ps
// ==========================================================
// two-entry skid buffer
module frusc_buf2 (
   // clock and reset
   input  wire       clock_i,
   input  wire       rst_b_i,
   input  wire       flush_i,
   // fill side
   input  wire [7:0] in_data_i,
   input  wire       in_valid_i,
   output wire       in_ready_o,
   // drain side
   output wire [7:0] out_data_o,
   output wire       out_valid_o,
   input  wire       out_ready_i
);
   reg [7:0] mem_reg [0:1];
   reg       wptr_reg;
   reg       rptr_reg;
   reg [1:0] count_reg;
   wire      push;
   wire      pop;

   assign in_ready_o  = (count_reg != 2'd2);
   assign out_valid_o = (count_reg != 2'd0);
   assign out_data_o  = mem_reg[rptr_reg];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clock_i) begin
      if (push) begin
         mem_reg[wptr_reg] <= in_data_i;
      end
   end

   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wptr_reg  <= 1'b0;
         rptr_reg  <= 1'b0;
         count_reg <= 2'd0;
      end else if (flush_i) begin
         wptr_reg  <= 1'b0;
         rptr_reg  <= 1'b0;
         count_reg <= 2'd0;
      end else begin
         if (push) begin
            wptr_reg <= ~wptr_reg;
         end
         if (pop) begin
            rptr_reg <= ~rptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // frusc_buf2

// [verification/frusc_cmd_assertions.sv]
`timescale 1ns/1ps
// ==========================================================
// port checker of the command interpreter
module frusc_cmd_chk (
   // clock and reset
   input wire logic       clock_i,
   input wire logic       rst_b_i,
   // link pins
   input wire logic       cs_b_i,
   input wire logic       sclk_i,
   input wire logic       si_i,
   input wire logic [2:0] upper_io_lines_i,
   input wire logic       so_o,
   input wire logic       so_oe_o,
   // engine side
   input wire logic       busy_i,
   input wire logic       abort_o,
   input wire logic       soft_reset_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence cs_idle_s;
      cs_b_i [*8];
   endsequence
   sequence quiet_s;
      !soft_reset_o [*8];
   endsequence
   oe_release_a: assert property ($rose(cs_b_i) |-> ##[1:6] !so_oe_o)
      else $error("output enable held after deselect");
   idle_quiet_a: assert property (cs_idle_s |-> !so_oe_o)
      else $error("output driven while deselected");
   reset_quiet_a: assert property ($rose(rst_b_i) |-> !so_oe_o && !soft_reset_o && !abort_o)
      else $error("outputs active after reset release");
   reset_gap_a: assert property (soft_reset_o |=> quiet_s)
      else $error("software reset repeated too soon");
   abort_cause_a: assert property (abort_o |-> soft_reset_o && $past(busy_i))
      else $error("abort without reset during busy");
   reset_idle_a: assert property (soft_reset_o |-> !so_oe_o)
      else $error("output driven at software reset");
   oe_frame_a: assert property ($rose(so_oe_o) |-> !$past(cs_b_i, 3))
      else $error("output enabled outside a frame");
   so_edge_a: assert property (so_oe_o && $changed(so_o) |-> !sclk_i)
      else $error("output bit changed while serial clock high");
endmodule // frusc_cmd_chk

bind frusc_cmd frusc_cmd_chk u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sclk_i(sclk_i),
   .si_i(si_i), .upper_io_lines_i(upper_io_lines_i), .so_o(so_o),
   .so_oe_o(so_oe_o), .busy_i(busy_i), .abort_o(abort_o),
   .soft_reset_o(soft_reset_o)
);

// [verification/frusc_host.sv]
`timescale 1ns/1ps
// ==========================================================
// host controller model, mode 0, serial clock still between frames
module frusc_host (
   // link pins
   output logic      cs_b_o,
   output logic      sclk_o,
   output logic      si_o,
   input  wire logic so_i
);
   initial begin
      cs_b_o = 1'b1;
      sclk_o = 1'b0;
      si_o   = 1'b0;
   end
   // one byte, msb first, data sampled on the rising edge
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si_o <= tx[i];
         #62.5 sclk_o <= 1'b1;
         rx[i] = so_i;
         #62.5 sclk_o <= 1'b0;
      end
   endtask
   task automatic start();
      #100 cs_b_o <= 1'b0;
      #100;
   endtask
   // released input line toggles so a stale level cannot pass
   task automatic stop();
      #100 cs_b_o <= 1'b1;
      si_o <= ~si_o;
      #300;
   endtask
endmodule // frusc_host

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   localparam logic [127:0] UID  = 128'hC001D00D0BADF00D1234ABCD5678EF90; // arbitrary
   localparam logic [7:0]   VEND = 8'hA7; // arbitrary
   localparam logic [191:0] TBL  = {32'h53464450, 32'h000101FF, 32'h00000109,
                                     32'h300000FF, VEND, 24'h000103, 32'h600000FF};
   logic       clock_i, rst_b_i, busy_i, cs_b, sclk, si, so_o, so_oe_o;
   logic       abort_o, soft_reset_o;
   logic [2:0] upper_io;
   logic [7:0] rd [0:31];
   int         n_mismatch, n_checks, n_sr, n_ab, cyc;

   frusc_cmd #(.UNIQUE_ID(UID), .VENDOR_ID(VEND)) u_dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk), .si_i(si),
      .upper_io_lines_i(upper_io), .so_o(so_o), .so_oe_o(so_oe_o), .busy_i(busy_i),
      .abort_o(abort_o), .soft_reset_o(soft_reset_o));
   // a released output line reads inverted, so a stale bit cannot pass
   wire        so_line = so_oe_o ? so_o : ~so_o;
   frusc_host u_host (.cs_b_o(cs_b), .sclk_o(sclk), .si_o(si), .so_i(so_line));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (soft_reset_o === 1'b1) n_sr++;
      if (abort_o === 1'b1) n_ab++;
      if (++cyc == 30000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   // first n_hdr header bytes sent, then n_rd bytes read with a dummy pattern on the input
   task automatic frame(input logic [39:0] hdr, input int n_hdr, input int n_rd);
      logic [7:0] b;
      u_host.start();
      for (int i = 0; i < n_hdr; i++) u_host.xfer(hdr[39-8*i -: 8], b);
      for (int i = 0; i < n_rd; i++) u_host.xfer(8'hA5, rd[i]);
      u_host.stop();
      check({7'h0, so_oe_o}, 8'h00, "output enable after frame");
   endtask
   task automatic t_table();
      frame({8'h5A, 24'h000000, 8'hC3}, 5, 26);
      for (int a = 0; a < 26; a++)
         check(rd[a], a < 24 ? TBL[191-8*a -: 8] : 8'hFF, "table byte");
   endtask
   task automatic t_table_cut();
      frame({8'h5A, 24'h00000F, 8'h3C}, 5, 2);
      check(rd[0], 8'hFF, "first byte at odd start");
      check(rd[1], VEND, "vendor byte after cut start");
   endtask
   task automatic t_uid();
      @(posedge clock_i);
      upper_io <= 3'b010;
      frame({8'h4B, 32'hC3C3C3C3}, 5, 16);
      for (int i = 0; i < 16; i++) check(rd[i], UID[127-8*i -: 8], "unique id byte");
   endtask
   task automatic rst_seq(input logic [7:0] a, b, c, input logic bz, input int e_sr, e_ab);
      @(posedge clock_i);
      busy_i <= bz;
      n_sr = 0;
      n_ab = 0;
      frame({a, 32'h0}, 1, 0);
      frame({b, 32'h0}, 1, 0);
      frame({c, 32'h0}, 1, 0);
      check(n_sr[7:0], e_sr[7:0], "software reset count");
      check(n_ab[7:0], e_ab[7:0], "abort count");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      rst_b_i  = 1'b0;
      busy_i   = 1'b0;
      upper_io = 3'b101;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      t_table();
      t_table_cut();
      t_uid();
      rst_seq(8'h00, 8'h66, 8'h99, 1'b0, 1, 0);
      rst_seq(8'h66, 8'h00, 8'h99, 1'b0, 0, 0);
      rst_seq(8'h66, 8'h4B, 8'h99, 1'b0, 0, 0);
      rst_seq(8'h99, 8'h00, 8'h99, 1'b0, 0, 0);
      rst_seq(8'h00, 8'h66, 8'h99, 1'b1, 1, 1);
      stop_test();
   end
endmodule // tb
